// >>> rsrq_map.svh
// Constants of the regulator sequencer: times, counts, widths, slew table.
// Assumes a 250 MHz clock; included by its bare name.
`ifndef RSRQ_MAP_SVH
`define RSRQ_MAP_SVH
// ****************************************
// Timing
// ****************************************
`define RSRQ_CLK_NS 4
`define RSRQ_POR_NS 1200000
`define RSRQ_PG_NS 100000
`define RSRQ_SC_NS 1000000
`define RSRQ_STEP_NS 500000
`define RSRQ_CEIL(t) (((t) + `RSRQ_CLK_NS - 1) / `RSRQ_CLK_NS)
`define RSRQ_FLOOR(t) ((t) / `RSRQ_CLK_NS)
// ****************************************
// Counter widths
// ****************************************
`define RSRQ_POR_W 19
`define RSRQ_SC_W 18
`define RSRQ_PG_W 15
`define RSRQ_STEP_W 17
`define RSRQ_RAMP_W 12
// ****************************************
// Cycles per voltage code step less one, by slew code
// ****************************************
`define RSRQ_SLEW0 12'h07D
`define RSRQ_SLEW1 12'h0FA
`define RSRQ_SLEW2 12'h1F4
`define RSRQ_SLEW3 12'h3E8
`define RSRQ_SLEW4 12'h5DC
`define RSRQ_SLEW5 12'h7D0
`define RSRQ_SLEW6 12'hBB8
`define RSRQ_SLEW7 12'hFA0
`define RSRQ_DUAL_SLEW_MAX 3'h1
`define RSRQ_SEQ_NUM 6
`endif

// >>> rsrq_pkg.sv
// Types of the regulator sequencer.
// Assumes rsrq_map.svh for nothing; types only.
package rsrq_pkg;
    typedef enum logic [1:0] {
        RST_RUN  = 2'b00,
        RST_HOLD = 2'b01,
        RST_POR  = 2'b10
    } rsrq_rst_type;

    typedef struct packed {
        logic       en;
        logic       pin;
        logic       fpwm;
        logic [7:0] vcode;
        logic [2:0] slew;
        logic [3:0] rise;
        logic [3:0] fall;
    } rsrq_buck_cfg_type;

    typedef struct packed {
        logic       en;
        logic       pin;
        logic [4:0] vcode;
        logic [3:0] rise;
        logic [3:0] fall;
    } rsrq_lin_cfg_type;

    typedef struct packed {
        logic       en;
        logic       pin;
        logic [3:0] rise;
        logic [3:0] fall;
    } rsrq_gpo_cfg_type;

    // Analog and pin inputs, all asynchronous
    typedef struct packed {
        logic       en_pin;
        logic       undervoltage_lockout;
        logic       heavy;
        logic [1:0] buck_ilim;
        logic [1:0] lin_ilim;
        logic [1:0] buck_low;
        logic [1:0] lin_low;
        logic [1:0] lin_pg;
    } rsrq_ain_type;

    typedef struct packed {
        logic [1:0] buck_ilim;
        logic [1:0] lin_ilim;
        logic [1:0] buck_sc;
        logic [1:0] lin_sc;
        logic       reset_event;
    } rsrq_flag_type;
endpackage

// >>> rsrq_seq_delay.sv
// One enable channel: direct enable or delayed enable-pin following.
// Assumes a synchronised pin level and a one-cycle timebase tick.
`timescale 1ns/1ps
module rsrq_seq_delay
    import rsrq_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset,
    input  wire logic       i_clk_en,
    input  wire logic       i_run,
    input  wire logic       i_pin_lvl,
    input  wire logic       i_tick,
    input  wire logic       i_en,
    input  wire logic       i_pin,
    input  wire logic [3:0] i_rise,
    input  wire logic [3:0] i_fall,
    output logic            o_on
);
    typedef struct packed {
        logic       on;
        logic [3:0] cnt;
    } rsrq_seq_type;

    rsrq_seq_type q_ff;
    rsrq_seq_type nxt_q;
    logic [3:0]   code;

    always_comb begin
        nxt_q = q_ff;
        code  = i_pin_lvl ? i_rise : i_fall;
        if (!i_run) begin
            nxt_q = '0;
        end else if (!(i_en && i_pin)) begin
            nxt_q.on  = i_en;
            nxt_q.cnt = '0;
        end else if (i_pin_lvl == q_ff.on) begin
            nxt_q.cnt = '0;
        end else if (q_ff.cnt == code) begin
            nxt_q.on  = i_pin_lvl;
            nxt_q.cnt = '0;
        end else if (i_tick) begin
            nxt_q.cnt = q_ff.cnt + 4'h1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            q_ff <= '0;
        end else if (i_clk_en) begin
            q_ff <= nxt_q;
        end
    end

    assign o_on = q_ff.on;

    chk_direct_no_delay: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_clk_en && i_run && !i_pin) |=> (o_on == $past(i_en)))
        else $error("direct enable was delayed");
endmodule // rsrq_seq_delay

// >>> rsrq_top.sv
// Regulator sequencer: ramps, enable sequencing, resets and flags.
// Assumes config ports on this clock; analog inputs are asynchronous.
`timescale 1ns/1ps
`include "rsrq_map.svh"
module rsrq_top
    import rsrq_pkg::*;
#(
    parameter logic [`RSRQ_POR_W-1:0] POR_CYC =
        `RSRQ_POR_W'(`RSRQ_CEIL(`RSRQ_POR_NS)),
    parameter logic [`RSRQ_PG_W-1:0] PG_CYC =
        `RSRQ_PG_W'(`RSRQ_FLOOR(`RSRQ_PG_NS)),
    parameter logic [`RSRQ_SC_W-1:0] SC_CYC =
        `RSRQ_SC_W'(`RSRQ_CEIL(`RSRQ_SC_NS)),
    parameter logic [`RSRQ_STEP_W-1:0] STEP_CYC =
        `RSRQ_STEP_W'(`RSRQ_CEIL(`RSRQ_STEP_NS))
)(
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_reset,
    input  wire logic                    i_clk_en,
    input  wire rsrq_ain_type            i_ain,
    input  wire rsrq_buck_cfg_type [1:0] i_buck_cfg,
    input  wire logic                    i_force_dual,
    input  wire rsrq_lin_cfg_type [1:0]  i_lin_cfg,
    input  wire rsrq_gpo_cfg_type [1:0]  i_gpo_cfg,
    input  wire logic                    i_software_reset_bit_wr,
    input  wire logic                    i_otp_reset_mask,
    input  wire rsrq_flag_type           i_flag_clr,
    output logic [1:0]                   o_buck_on,
    output logic [1:0][7:0]              o_buck_vcode,
    output logic [1:0]                   o_buck_ramping,
    output logic [1:0]                   o_buck_fpwm,
    output logic                         o_buck_dual,
    output logic [1:0]                   o_lin_on,
    output logic [1:0][4:0]              o_lin_vcode,
    output logic [1:0]                   o_lin_pg,
    output logic [1:0]                   o_gpo,
    output rsrq_flag_type                o_flags,
    output logic                         o_buck_grp,
    output logic                         o_lin_grp,
    output logic                         o_int_n,
    output logic                         o_regs_default,
    output logic                         o_ready
);
    localparam logic [`RSRQ_STEP_W-1:0] STEP_LAST =
        STEP_CYC - `RSRQ_STEP_W'(1);

    typedef struct packed {
        rsrq_ain_type                      s1;
        rsrq_ain_type                      s2;
        rsrq_rst_type                      rst;
        logic [`RSRQ_POR_W-1:0]            por_cnt;
        logic                              cause;
        logic                              otp_mask;
        logic [`RSRQ_STEP_W-1:0]           tick_cnt;
        logic                              tick;
        logic [1:0][`RSRQ_RAMP_W-1:0]      ramp_cnt;
        logic [1:0][`RSRQ_SC_W-1:0]        bsc_cnt;
        logic [1:0][`RSRQ_SC_W-1:0]        lsc_cnt;
        logic [1:0][`RSRQ_PG_W-1:0]        pg_cnt;
        logic [1:0]                        buck_on;
        logic [1:0][7:0]                   bv;
        logic [1:0]                        ramping;
        logic [1:0]                        fpwm;
        logic                              dual;
        logic [1:0]                        lin_on;
        logic [1:0][4:0]                   lv;
        logic [1:0]                        lpg;
        logic [1:0]                        general_output_a;
        rsrq_flag_type                     flags;
        logic                              buck_grp;
        logic                              lin_grp;
        logic                              int_n;
        logic                              regs_default;
        logic                              ready;
    } rsrq_state_type;

    rsrq_state_type                q_ff;
    rsrq_state_type                nxt_q;
    logic                          run_now;
    logic [`RSRQ_SEQ_NUM-1:0]      seq_en;
    logic [`RSRQ_SEQ_NUM-1:0]      seq_pin;
    logic [`RSRQ_SEQ_NUM-1:0][3:0] seq_rise;
    logic [`RSRQ_SEQ_NUM-1:0][3:0] seq_fall;
    logic [`RSRQ_SEQ_NUM-1:0]      seq_on;

    // Cycles between voltage code steps, less one, for a slew code
    function automatic logic [`RSRQ_RAMP_W-1:0] slew_period(
        input logic [2:0] code
    );
        logic [`RSRQ_RAMP_W-1:0] p;
        p = `RSRQ_SLEW0;
        unique case (code)
            3'h0: p = `RSRQ_SLEW0;
            3'h1: p = `RSRQ_SLEW1;
            3'h2: p = `RSRQ_SLEW2;
            3'h3: p = `RSRQ_SLEW3;
            3'h4: p = `RSRQ_SLEW4;
            3'h5: p = `RSRQ_SLEW5;
            3'h6: p = `RSRQ_SLEW6;
            3'h7: p = `RSRQ_SLEW7;
        endcase
        return p;
    endfunction

    // ****************************************
    // Enable channels: bucks, linregs, outputs
    // ****************************************
    assign seq_en   = {i_gpo_cfg[1].en, i_gpo_cfg[0].en,
                       i_lin_cfg[1].en, i_lin_cfg[0].en,
                       i_buck_cfg[1].en, i_buck_cfg[0].en};
    assign seq_pin  = {i_gpo_cfg[1].pin, i_gpo_cfg[0].pin,
                       i_lin_cfg[1].pin, i_lin_cfg[0].pin,
                       i_buck_cfg[1].pin, i_buck_cfg[0].pin};
    assign seq_rise = {i_gpo_cfg[1].rise, i_gpo_cfg[0].rise,
                       i_lin_cfg[1].rise, i_lin_cfg[0].rise,
                       i_buck_cfg[1].rise, i_buck_cfg[0].rise};
    assign seq_fall = {i_gpo_cfg[1].fall, i_gpo_cfg[0].fall,
                       i_lin_cfg[1].fall, i_lin_cfg[0].fall,
                       i_buck_cfg[1].fall, i_buck_cfg[0].fall};

    // Channel order: buck0, buck1, linreg0, linreg1, out a, out b
    for (genvar c = 0; c < `RSRQ_SEQ_NUM; c++) begin : g_seq
        rsrq_seq_delay u_seq (
            .i_ref_clk (i_ref_clk),
            .i_reset   (i_reset),
            .i_clk_en  (i_clk_en),
            .i_run     (run_now),
            .i_pin_lvl (q_ff.s2.en_pin),
            .i_tick    (q_ff.tick),
            .i_en      (seq_en[c]),
            .i_pin     (seq_pin[c]),
            .i_rise    (seq_rise[c]),
            .i_fall    (seq_fall[c]),
            .o_on      (seq_on[c])
        );
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_q    = q_ff;
        nxt_q.s1 = i_ain;
        nxt_q.s2 = q_ff.s1;
        run_now  = (q_ff.rst == RST_RUN) && !q_ff.s2.undervoltage_lockout
                   && !i_software_reset_bit_wr;

        // Reset sequence
        unique case (q_ff.rst)
            RST_RUN: begin
                if (q_ff.s2.undervoltage_lockout || i_software_reset_bit_wr) begin
                    nxt_q.rst   = RST_HOLD;
                    nxt_q.cause = 1'b1;
                end
            end
            RST_HOLD: begin
                if (!q_ff.s2.undervoltage_lockout) begin
                    nxt_q.rst     = RST_POR;
                    nxt_q.por_cnt = '0;
                end
            end
            RST_POR: begin
                if (q_ff.s2.undervoltage_lockout) begin
                    nxt_q.rst = RST_HOLD;
                end else if (q_ff.por_cnt == POR_CYC) begin
                    nxt_q.rst      = RST_RUN;
                    nxt_q.otp_mask = i_otp_reset_mask;
                end else begin
                    nxt_q.por_cnt = q_ff.por_cnt
                                    + `RSRQ_POR_W'(1);
                end
            end
            default: begin
                nxt_q.rst = RST_HOLD;
            end
        endcase

        // Delay timebase
        nxt_q.tick = (q_ff.tick_cnt == STEP_LAST);
        if (nxt_q.tick) begin
            nxt_q.tick_cnt = '0;
        end else begin
            nxt_q.tick_cnt = q_ff.tick_cnt + `RSRQ_STEP_W'(1);
        end

        // Flags: set wins over write-1 clear
        nxt_q.flags = q_ff.flags & ~i_flag_clr;
        nxt_q.flags.buck_ilim = nxt_q.flags.buck_ilim
                                | q_ff.s2.buck_ilim;
        nxt_q.flags.lin_ilim  = nxt_q.flags.lin_ilim
                                | q_ff.s2.lin_ilim;

        for (int b = 0; b < 2; b++) begin
            // Buck enable, ramp and short detection
            nxt_q.buck_on[b] = run_now && seq_on[b]
                               && !q_ff.flags.buck_sc[b];
            if (!q_ff.buck_on[b]) begin
                nxt_q.bv[b]       = i_buck_cfg[b].vcode;
                nxt_q.ramp_cnt[b] = '0;
            end else if (q_ff.bv[b] != i_buck_cfg[b].vcode) begin
                if (q_ff.ramp_cnt[b]
                    >= slew_period(i_buck_cfg[b].slew)) begin
                    nxt_q.ramp_cnt[b] = '0;
                    if (q_ff.bv[b] < i_buck_cfg[b].vcode) begin
                        nxt_q.bv[b] = q_ff.bv[b] + 8'h01;
                    end else begin
                        nxt_q.bv[b] = q_ff.bv[b] - 8'h01;
                    end
                end else begin
                    nxt_q.ramp_cnt[b] = q_ff.ramp_cnt[b]
                                        + `RSRQ_RAMP_W'(1);
                end
            end else begin
                nxt_q.ramp_cnt[b] = '0;
            end
            nxt_q.ramping[b] = nxt_q.buck_on[b]
                               && (nxt_q.bv[b] != i_buck_cfg[b].vcode);
            nxt_q.fpwm[b]    = nxt_q.ramping[b]
                               || i_buck_cfg[b].fpwm;

            if (q_ff.buck_on[b] && q_ff.s2.buck_low[b]) begin
                if (q_ff.bsc_cnt[b] == SC_CYC) begin
                    nxt_q.flags.buck_sc[b] = 1'b1;
                    nxt_q.bsc_cnt[b]       = '0;
                end else begin
                    nxt_q.bsc_cnt[b] = q_ff.bsc_cnt[b]
                                       + `RSRQ_SC_W'(1);
                end
            end else begin
                nxt_q.bsc_cnt[b] = '0;
            end

            // Linreg enable, short detection, power-good settling
            nxt_q.lin_on[b] = run_now && seq_on[b+2]
                              && !q_ff.flags.lin_sc[b];
            nxt_q.lv[b]     = i_lin_cfg[b].vcode;
            if (q_ff.lin_on[b] && q_ff.s2.lin_low[b]) begin
                if (q_ff.lsc_cnt[b] == SC_CYC) begin
                    nxt_q.flags.lin_sc[b] = 1'b1;
                    nxt_q.lsc_cnt[b]      = '0;
                end else begin
                    nxt_q.lsc_cnt[b] = q_ff.lsc_cnt[b]
                                       + `RSRQ_SC_W'(1);
                end
            end else begin
                nxt_q.lsc_cnt[b] = '0;
            end
            if (i_lin_cfg[b].vcode != q_ff.lv[b]) begin
                nxt_q.pg_cnt[b] = PG_CYC;
            end else if (q_ff.pg_cnt[b] != '0) begin
                nxt_q.pg_cnt[b] = q_ff.pg_cnt[b] - `RSRQ_PG_W'(1);
            end else begin
                nxt_q.lpg[b] = q_ff.lin_on[b] && q_ff.s2.lin_pg[b];
            end
            if (!q_ff.lin_on[b]) begin
                nxt_q.lpg[b] = 1'b0;
            end

            nxt_q.general_output_a[b] = run_now && seq_on[b+4];
        end

        // Phase selection for buck0
        if (nxt_q.ramping[0]) begin
            nxt_q.dual = i_force_dual
                         || (i_buck_cfg[0].slew
                             <= `RSRQ_DUAL_SLEW_MAX);
        end else begin
            nxt_q.dual = nxt_q.buck_on[0]
                         && (i_force_dual || q_ff.s2.heavy);
        end

        // Registers at defaults while in reset
        if (!run_now) begin
            nxt_q.flags    = '0;
            nxt_q.ramp_cnt = '0;
            nxt_q.bsc_cnt  = '0;
            nxt_q.lsc_cnt  = '0;
            nxt_q.pg_cnt   = '0;
            nxt_q.ramping  = '0;
            nxt_q.fpwm     = '0;
            nxt_q.dual     = 1'b0;
            nxt_q.lpg      = '0;
        end
        if (q_ff.rst == RST_POR && nxt_q.rst == RST_RUN) begin
            nxt_q.flags.reset_event = q_ff.cause
                                      && !nxt_q.otp_mask;
            nxt_q.cause = 1'b0;
        end

        nxt_q.buck_grp = |{nxt_q.flags.buck_ilim,
                           nxt_q.flags.buck_sc};
        nxt_q.lin_grp  = |{nxt_q.flags.lin_ilim,
                           nxt_q.flags.lin_sc};
        nxt_q.int_n    = !(|nxt_q.flags);
        nxt_q.regs_default = (nxt_q.rst != RST_RUN);
        nxt_q.ready        = (nxt_q.rst == RST_RUN);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            q_ff       <= '0;
            q_ff.rst   <= RST_POR;
            q_ff.int_n <= 1'b1;
            q_ff.regs_default <= 1'b1;
        end else if (i_clk_en) begin
            q_ff <= nxt_q;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_buck_on      = q_ff.buck_on;
    assign o_buck_vcode   = q_ff.bv;
    assign o_buck_ramping = q_ff.ramping;
    assign o_buck_fpwm    = q_ff.fpwm;
    assign o_buck_dual    = q_ff.dual;
    assign o_lin_on       = q_ff.lin_on;
    assign o_lin_vcode    = q_ff.lv;
    assign o_lin_pg       = q_ff.lpg;
    assign o_gpo          = q_ff.general_output_a;
    assign o_flags        = q_ff.flags;
    assign o_buck_grp     = q_ff.buck_grp;
    assign o_lin_grp      = q_ff.lin_grp;
    assign o_int_n        = q_ff.int_n;
    assign o_regs_default = q_ff.regs_default;
    assign o_ready        = q_ff.ready;

    // ****************************************
    // Checks
    // ****************************************
    chk_int_pin_flags: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        o_int_n == !(|o_flags))
        else $error("interrupt pin disagrees with flags");

    chk_software_reset_bit_off: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_clk_en && i_software_reset_bit_wr) |=>
        (o_buck_on == 2'h0 && o_lin_on == 2'h0 && o_gpo == 2'h0
         && o_regs_default))
        else $error("software reset left outputs on");

    chk_undervoltage_lockout_off: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_clk_en && q_ff.s2.undervoltage_lockout) |=>
        (o_buck_on == 2'h0 && o_lin_on == 2'h0 && o_gpo == 2'h0
         && o_flags == '0))
        else $error("undervoltage left outputs on");

    chk_ilim_hold: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_clk_en && run_now && q_ff.s2.buck_ilim[0]) |=>
        o_flags.buck_ilim[0])
        else $error("overcurrent flag cleared while active");

    chk_fpwm_ramp: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (o_buck_ramping[0] |-> o_buck_fpwm[0])
        and (o_buck_ramping[1] |-> o_buck_fpwm[1]))
        else $error("ramp without fixed switching");

    chk_dual_forced: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_clk_en && i_force_dual && nxt_q.ramping[0]) |=> o_buck_dual)
        else $error("forced dual phase not used in ramp");

    chk_mode_settled: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_clk_en && run_now && !nxt_q.ramping[0]) |=>
        (o_buck_fpwm[0] == $past(i_buck_cfg[0].fpwm)))
        else $error("settled mode ignores fixed switching bit");

    chk_short_off: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_clk_en && o_flags.buck_sc[0]) |=> !o_buck_on[0])
        else $error("buck stays on after short");

    chk_reset_event: assert property (@(posedge i_ref_clk)
        disable iff (i_reset)
        (i_clk_en && q_ff.rst == RST_POR && nxt_q.rst == RST_RUN
         && q_ff.cause && !i_otp_reset_mask) |=>
        (o_flags.reset_event && !o_int_n))
        else $error("reset event not reported");
endmodule // rsrq_top

// >>> rsrq_analog_model.sv
// Analog stage model: regulator outputs, limits and pin levels.
// Assumes the sequencer's enables; the bench sets pin and limits.
`timescale 1ns/1ps
module rsrq_analog_model
    import rsrq_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic [1:0] i_buck_on,
    input  wire logic [1:0] i_lin_on,
    input  wire logic       i_en_pin,
    input  wire logic [1:0] i_ilim,
    input  wire logic [1:0] i_lin_ilim,
    input  wire logic       i_undervoltage_lockout,
    input  wire logic       i_heavy,
    input  wire logic [1:0] i_short,
    output rsrq_ain_type    o_ain
);
    // ****************************************
    // Buck output rises one cycle after enable; linreg output follows its enable at once
    // ****************************************
    logic [1:0] up_ff = 2'h0;
    always_ff @(posedge i_ref_clk) begin
        up_ff <= i_buck_on;
    end
    assign o_ain = {i_en_pin, i_undervoltage_lockout, i_heavy, i_ilim, i_lin_ilim,
                    ~up_ff | i_short, ~i_lin_on, i_lin_on};
endmodule // rsrq_analog_model

// >>> rsrq_top_tb_top.sv
// Bench of the regulator sequencer with shortened counts.
// Assumes rsrq_top and the analog stage model.
`timescale 1ns/1ps
module rsrq_top_tb_top
    import rsrq_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, sw = 1'b0, msk = 1'b0, pin = 1'b0;
    logic [1:0] ilim = 2'h0, bon, lon, general_output_a;
    logic ce = 1'b1, fd = 1'b0, uv = 1'b0, heavy = 1'b0, dual, bgrp, lgrp;
    logic [1:0] lilim = 2'h0, sc = 2'h0, rmp, fpw, lpg;
    logic [1:0][7:0] bvc;
    logic [1:0][4:0] lvc;
    rsrq_ain_type ain;
    rsrq_buck_cfg_type [1:0] bcfg = '0;
    rsrq_lin_cfg_type [1:0] lcfg = '0;
    rsrq_gpo_cfg_type [1:0] gcfg = '0;
    rsrq_flag_type clr = '0, flg;
    logic int_n, rdef, rdy;
    int mismatches = 0, compares = 0;
    initial forever #2 clk = ~clk;
    rsrq_top #(.POR_CYC(19'h14), .PG_CYC(15'h8), .SC_CYC(18'hA),
        .STEP_CYC(17'h4)) i_dut (.i_ref_clk(clk), .i_reset(rst),
        .i_clk_en(ce), .i_ain(ain), .i_buck_cfg(bcfg),
        .i_force_dual(fd), .i_lin_cfg(lcfg), .i_gpo_cfg(gcfg),
        .i_software_reset_bit_wr(sw), .i_otp_reset_mask(msk), .i_flag_clr(clr),
        .o_buck_on(bon), .o_buck_vcode(bvc), .o_buck_ramping(rmp),
        .o_buck_fpwm(fpw), .o_buck_dual(dual), .o_lin_on(lon),
        .o_lin_vcode(lvc), .o_lin_pg(lpg), .o_gpo(general_output_a), .o_flags(flg),
        .o_buck_grp(bgrp), .o_lin_grp(lgrp), .o_int_n(int_n),
        .o_regs_default(rdef), .o_ready(rdy));
    rsrq_analog_model i_ana (.i_ref_clk(clk), .i_buck_on(bon),
        .i_lin_on(lon), .i_en_pin(pin), .i_ilim(ilim),
        .i_lin_ilim(lilim), .i_undervoltage_lockout(uv), .i_heavy(heavy), .i_short(sc),
        .o_ain(ain));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        check("ready", rdy, 1);
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_direct();
        ce <= 1'b0;
        bcfg[0].en <= 1'b1;
        bcfg[0].rise <= 4'hF;
        cyc(3);
        check("frozen", bon[0], 0);
        ce <= 1'b1;
        cyc(3);
        check("buck on", bon[0], 1);
        bcfg[0].en <= 1'b0;
        cyc(3);
        check("buck off", bon[0], 0);
    endtask
    task automatic t_pin();
        gcfg[1] <= '{en: 1'b1, pin: 1'b1, rise: 4'h2, fall: 4'h0};
        lcfg[0] <= '{en: 1'b1, pin: 1'b1, vcode: 5'h3, rise: 4'h0,
                     fall: 4'h0};
        pin <= 1'b1;
        cyc(3);
        check("gpo early", general_output_a[1], 0);
        cyc(15);
        check("gpo late", general_output_a[1], 1);
        check("linreg", lon[0], 1);
        check("linreg vcode", lvc[0], 3);
        check("linreg pg", lpg[0], 1);
        pin <= 1'b0;
        cyc(6);
        check("gpo fall", general_output_a[1], 0);
    endtask
    task automatic t_ilim();
        ilim <= 2'h1;
        lilim <= 2'h2;
        cyc(5);
        check("ilim flag", flg.buck_ilim, 1);
        check("lin ilim", flg.lin_ilim, 2);
        check("buck grp", bgrp, 1);
        check("lin grp", lgrp, 1);
        check("int low", int_n, 0);
        clr.buck_ilim <= 2'h1;
        cyc(1);
        clr <= '0;
        cyc(2);
        check("ilim held", flg.buck_ilim, 1);
        ilim <= 2'h0;
        lilim <= 2'h0;
        cyc(4);
        clr <= '{buck_ilim: 2'h1, lin_ilim: 2'h2, default: '0};
        cyc(1);
        clr <= '0;
        cyc(2);
        check("ilim clr", flg.buck_ilim, 0);
        check("lin clr", lgrp, 0);
        check("int high", int_n, 1);
    endtask
    task automatic t_swrst(input logic m);
        msk <= m;
        bcfg[1].en <= 1'b1;
        cyc(4);
        sw <= 1'b1;
        cyc(1);
        sw <= 1'b0;
        cyc(2);
        check("off", bon[1], 0);
        check("defaults", rdef, 1);
        wait_ready();
        check("event", flg.reset_event, !m);
        clr.reset_event <= 1'b1;
        cyc(1);
        clr <= '0;
        cyc(2);
    endtask
    task automatic t_ramp();
        bcfg[0] <= '{en: 1'b1, pin: 1'b0, fpwm: 1'b0, vcode: 8'h00,
                     slew: 3'h2, rise: 4'h0, fall: 4'h0};
        cyc(3);
        bcfg[0].vcode <= 8'h01;
        fd <= 1'b1;
        cyc(3);
        check("ramping", rmp[0], 1);
        check("ramp fpwm", fpw[0], 1);
        check("forced dual", dual, 1);
        cyc(495);
        check("slow step", bvc[0], 0);
        cyc(6);
        check("step", bvc[0], 1);
        check("settled", rmp[0], 0);
        check("settled fpwm", fpw[0], 0);
        fd <= 1'b0;
        heavy <= 1'b1;
        bcfg[0].fpwm <= 1'b1;
        cyc(5);
        check("heavy dual", dual, 1);
        check("fpwm bit", fpw[0], 1);
        heavy <= 1'b0;
        bcfg[0].fpwm <= 1'b0;
        bcfg[0].slew <= 3'h0;
        bcfg[0].vcode <= 8'h00;
        cyc(3);
        check("auto dual", dual, 1);
        cyc(130);
        check("down", bvc[0], 0);
        check("light", dual, 0);
    endtask
    task automatic t_short();
        sc <= 2'h1;
        cyc(8);
        check("no short yet", flg.buck_sc, 0);
        cyc(8);
        check("short flag", flg.buck_sc, 1);
        check("short off", bon[0], 0);
        check("short grp", bgrp, 1);
        sc <= 2'h0;
        clr.buck_sc <= 2'h1;
        cyc(1);
        clr <= '0;
        cyc(4);
        check("short clr", flg.buck_sc, 0);
        check("short restart", bon[0], 1);
    endtask
    task automatic t_undervoltage_lockout();
        msk <= 1'b0;
        uv <= 1'b1;
        cyc(5);
        check("undervoltage_lockout off", bon[0], 0);
        check("undervoltage_lockout defaults", rdef, 1);
        uv <= 1'b0;
        wait_ready();
        check("undervoltage_lockout event", flg.reset_event, 1);
        cyc(3);
        check("undervoltage_lockout restart", bon[0], 1);
    endtask
    initial begin
        cyc(20);
        rst <= 1'b0;
        wait_ready();
        check("no event", flg.reset_event, 0);
        t_direct();
        t_pin();
        t_ilim();
        t_ramp();
        t_short();
        t_swrst(1'b0);
        t_swrst(1'b1);
        t_undervoltage_lockout();
        results();
    end
    initial begin
        cyc(5000);
        mismatches++;
        results();
    end
endmodule // rsrq_top_tb_top
